// [core/bpp_defines.svh]
// Register offsets, widths and reset values of the parallel port block
`ifndef BPP_DEFINES_SVH
`define BPP_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define BPP_IDX_PORT_A_LATCH 3'h0
`define BPP_IDX_PORT_B_LATCH 3'h1
`define BPP_IDX_PORT_C_LATCH 3'h2
`define BPP_IDX_TONE_CTRL 3'h4
`define BPP_IDX_PORT_A_DIR 3'h5
`define BPP_IDX_PORT_B_DIR 3'h6
`define BPP_IDX_PORT_C_DIR 3'h7

// Port widths
`define BPP_PORT_A_WIDTH 7
`define BPP_PORT_BC_WIDTH 8

// Reset values
`define BPP_DIR_RESET 8'h00
`define BPP_TONE_RESET 8'h00

// Tone converter control fields
`define BPP_TONE_EN_BIT 7
`define BPP_TONE_LEVEL_MSB 5

// Port A line used by the tone converter
`define BPP_TONE_LINE 1

// Port A line taken by the oscillator on the reduced variant
`define BPP_OSC_LINE 0

`endif

// [core/bpp_pkg.sv]
// Types shared by the parallel port block
package bpp_pkg;

    // Pin group of one 8-bit port: output value, output enable
    typedef struct packed {
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
    } bpp_pad_drive_s;

    // Decoded register select
    typedef enum logic [2:0] {
        BPP_SEL_NONE,
        BPP_SEL_LATCH,
        BPP_SEL_DIR,
        BPP_SEL_TONE
    } bpp_sel_e;

endpackage

// [core/bpp_port_slice.sv]
// One 8-bit bidirectional port: output latch, direction register, read mux
`timescale 1ns/100ps
`default_nettype none
`include "bpp_defines.svh"
module bpp_port_slice
    import bpp_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hff // Lines that exist
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic latch_we,
    input wire logic dir_we,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] pin_in,
    output logic [7:0] read_value,
    output bpp_pad_drive_s pad
);

    logic [7:0] latch; // Output data latch, no reset
    logic [7:0] dir; // Direction, 1 drives the pin

    // Latch written regardless of direction; never touched by reset
    always_ff @(posedge clock) begin
        if (latch_we) begin
            latch <= wr_data & IMPL_MASK;
        end
    end

    // Direction cleared by every reset
    always_ff @(posedge clock) begin
        if (reset) begin
            dir <= `BPP_DIR_RESET;
        end else if (dir_we) begin
            dir <= wr_data & IMPL_MASK;
        end
    end

    // Per-bit read source and pad drive
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            // Output lines read the latch, input lines read the pin
            assign read_value[i] = IMPL_MASK[i] & (dir[i] ? latch[i] : pin_in[i]);
            // Drive only while the direction bit is set
            assign pad.pin_oe[i] = IMPL_MASK[i] & dir[i];
            assign pad.pin_out[i] = latch[i] & IMPL_MASK[i];
        end
    endgenerate

endmodule
`default_nettype wire

// [core/bpp_ports.sv]
// Three bidirectional parallel ports behind a classic Wishbone slave
//
// Functional notes
// - Ports A seven, B and C eight bits
// - Reduced variant: port A six bits
// - Write with direction 0 only loads latch
// - Write with direction 1 latches and drives
// - Input bit reads the pin level
// - Output bit reads the output latch
// - Data latches at indices 0, 1, 2
// - Data latches untouched by reset
// - Reset clears tone converter control
// - Direction registers at 5, 6, 7
// - Reset clears all direction bits
//
// Register map, byte address with the index in bits 4:2
//   0x00 port A latch, 0x04 port B latch, 0x08 port C latch
//   0x10 tone converter control
//   0x14 port A direction, 0x18 port B, 0x1c port C
//   Index 3 and misaligned addresses answer with err
//
// Bus timing
//   Request taken at a rising edge with cyc and stb high
//   Ack or err one cycle later, high for one cycle
//   A request still up in the ack cycle is not taken again
//   Read data registered, held until the next read
//   Writes use byte lane 0; sel bit 0 low makes them a no-op
//
// Pins
//   Pin out follows the latch, oe follows the direction bit
//   Latches have no reset and are unknown until written
//   Tone enable takes port A line 1 off the pin drivers
//   Pin inputs used as synchronous, no synchroniser
//
// Variant
//   Reduced port A: line 0 absent, reads zero, never driven
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bpp_defines.svh"
module bpp_ports
    import bpp_pkg::*;
#(
    parameter bit REDUCED_PORT_A = 1'b0 // Oscillator owns port A line 0
) (
    input wire logic clock,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Port A pins
    input wire logic [6:0] port_a_in,
    output logic [6:0] port_a_out,
    output logic [6:0] port_a_oe,
    // Port B pins
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    // Port C pins
    input wire logic [7:0] port_c_in,
    output logic [7:0] port_c_out,
    output logic [7:0] port_c_oe,
    // Tone converter sample level for port A line 1
    output logic [5:0] tone_level
);

    // Port A implemented lines: seven, or six when line 0 is the oscillator
    localparam logic [7:0] PORT_A_MASK = REDUCED_PORT_A ? 8'h7e : 8'h7f;

    logic req; // Access presented
    logic [2:0] idx; // Register index
    logic aligned_ok; // Address is word-aligned, any index
    bpp_sel_e sel; // Decoded register kind
    logic [1:0] port_sel; // Which port
    logic wr_lane0; // Byte lane 0 enabled on write
    logic [2:0] latch_we; // Per-port latch write
    logic [2:0] dir_we; // Per-port direction write
    logic tone_we; // Tone control write
    logic [7:0] rd_a; // Port A read value
    logic [7:0] rd_b; // Port B read value
    logic [7:0] rd_c; // Port C read value
    logic [7:0] tone_ctrl; // Tone control contents
    logic tone_active; // Converter owns line 1
    logic [7:0] next_rd; // Read data for this access
    bpp_pad_drive_s pad_a; // Port A drive
    bpp_pad_drive_s pad_b; // Port B drive
    bpp_pad_drive_s pad_c; // Port C drive
    logic [7:0] pin_a_ext; // Port A pins widened

    // New request while no ack outstanding
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign idx = wb_adr_i[4:2];
    assign aligned_ok = (wb_adr_i[1:0] == 2'h0);
    assign wr_lane0 = wb_we_i & wb_sel_i[0];

    // Address decode
    // Index 3 is a hole in the map and answers with err
    // Misaligned byte addresses decode to no register at all
    always_comb begin
        // Defaults: nothing selected, port A index
        sel = BPP_SEL_NONE;
        port_sel = 2'h0;
        // Only word-aligned addresses reach a register
        if (aligned_ok) begin
            unique case (idx)
                `BPP_IDX_PORT_A_LATCH: begin
                    sel = BPP_SEL_LATCH;
                    port_sel = 2'h0;
                end
                `BPP_IDX_PORT_B_LATCH: begin
                    sel = BPP_SEL_LATCH;
                    port_sel = 2'h1;
                end
                `BPP_IDX_PORT_C_LATCH: begin
                    sel = BPP_SEL_LATCH;
                    port_sel = 2'h2;
                end
                `BPP_IDX_TONE_CTRL: begin
                    sel = BPP_SEL_TONE;
                end
                `BPP_IDX_PORT_A_DIR: begin
                    sel = BPP_SEL_DIR;
                    port_sel = 2'h0;
                end
                `BPP_IDX_PORT_B_DIR: begin
                    sel = BPP_SEL_DIR;
                    port_sel = 2'h1;
                end
                `BPP_IDX_PORT_C_DIR: begin
                    sel = BPP_SEL_DIR;
                    port_sel = 2'h2;
                end
                default: begin
                    sel = BPP_SEL_NONE;
                end
            endcase
        end
    end

    // Write strobes, one cycle with the request
    // Writes with byte lane 0 off are acknowledged with no effect
    // Latch and direction strobes share one port index
    always_comb begin
        // Defaults: no register written
        latch_we = 3'h0;
        dir_we = 3'h0;
        if (req & wr_lane0 & (sel == BPP_SEL_LATCH)) begin
            latch_we[port_sel] = 1'b1;
        end
        if (req & wr_lane0 & (sel == BPP_SEL_DIR)) begin
            dir_we[port_sel] = 1'b1;
        end
    end
    assign tone_we = req & wr_lane0 & (sel == BPP_SEL_TONE);

    assign pin_a_ext = {1'b0, port_a_in};

    // Port A
    bpp_port_slice #(
        .IMPL_MASK(PORT_A_MASK)
    ) u_port_a (
        .clock(clock),
        .reset(reset),
        .latch_we(latch_we[0]),
        .dir_we(dir_we[0]),
        .wr_data(wb_dat_i[7:0]),
        .pin_in(pin_a_ext),
        .read_value(rd_a),
        .pad(pad_a)
    );

    // Port B; ports B and C implement all eight lines
    // All lines present, no mask beyond eight bits
    bpp_port_slice #(
        .IMPL_MASK(8'hff)
    ) u_port_b (
        .clock(clock),
        .reset(reset),
        .latch_we(latch_we[1]),
        .dir_we(dir_we[1]),
        .wr_data(wb_dat_i[7:0]),
        .pin_in(port_b_in),
        .read_value(rd_b),
        .pad(pad_b)
    );

    // Port C
    bpp_port_slice #(
        .IMPL_MASK(8'hff)
    ) u_port_c (
        .clock(clock),
        .reset(reset),
        .latch_we(latch_we[2]),
        .dir_we(dir_we[2]),
        .wr_data(wb_dat_i[7:0]),
        .pin_in(port_c_in),
        .read_value(rd_c),
        .pad(pad_c)
    );

    // Tone converter control
    bpp_tone_ctrl u_tone (
        .clock(clock),
        .reset(reset),
        .ctrl_we(tone_we),
        .wr_data(wb_dat_i[7:0]),
        .ctrl(tone_ctrl),
        .tone_active(tone_active)
    );

    // Read mux; direction reads back the drive mask
    // Unimplemented lines of port A read as zero
    always_comb begin
        // Default: zero for no register selected
        next_rd = 8'h00;
        unique case (sel)
            BPP_SEL_LATCH: begin
                // Per-bit pin or latch mix from the slice
                if (port_sel == 2'h0) begin
                    next_rd = rd_a;
                end else if (port_sel == 2'h1) begin
                    next_rd = rd_b;
                end else begin
                    next_rd = rd_c;
                end
            end
            BPP_SEL_DIR: begin
                if (port_sel == 2'h0) begin
                    next_rd = pad_a.pin_oe;
                end else if (port_sel == 2'h1) begin
                    next_rd = pad_b.pin_oe;
                end else begin
                    next_rd = pad_c.pin_oe;
                end
            end
            BPP_SEL_TONE: begin
                next_rd = tone_ctrl;
            end
            BPP_SEL_NONE: begin
                next_rd = 8'h00;
            end
        endcase
    end

    // Ack for mapped addresses, one cycle after the request
    // Never high two cycles in a row, so a held strobe is safe
    always_ff @(posedge clock) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & (sel != BPP_SEL_NONE);
        end
    end

    // Error for unmapped or misaligned addresses
    // Same timing as ack; the two never rise together
    always_ff @(posedge clock) begin
        if (reset) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= req & (sel == BPP_SEL_NONE);
        end
    end

    // Registered read data, upper bits zero
    // Writes leave the last read value in place
    always_ff @(posedge clock) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_we_i) begin
            wb_dat_o <= {24'h00_0000, next_rd};
        end
    end

    // Port A pads; converter takes line 1 only when enabled
    // Line 1 latch keeps its value while the converter owns the pin
    always_comb begin
        port_a_out = pad_a.pin_out[6:0];
        port_a_oe = pad_a.pin_oe[6:0];
        if (tone_active) begin
            port_a_out[`BPP_TONE_LINE] = 1'b0;
            port_a_oe[`BPP_TONE_LINE] = 1'b0;
        end
    end

    // Converter level output, zero while disabled
    // Level bits leave the block only while the converter runs
    assign tone_level = tone_active ? tone_ctrl[`BPP_TONE_LEVEL_MSB:0] : 6'h00;

    assign port_b_out = pad_b.pin_out;
    assign port_b_oe = pad_b.pin_oe;
    assign port_c_out = pad_c.pin_out;
    assign port_c_oe = pad_c.pin_oe;

endmodule
`default_nettype wire

// [core/bpp_tone_ctrl.sv]
// Tone converter control register that can take over port A line 1
`timescale 1ns/100ps
`default_nettype none
`include "bpp_defines.svh"
module bpp_tone_ctrl (
    input wire logic clock,
    input wire logic reset,
    input wire logic ctrl_we,
    input wire logic [7:0] wr_data,
    output logic [7:0] ctrl,
    output logic tone_active
);

    // Control bits cleared on reset so the line is a plain port pin
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl <= `BPP_TONE_RESET;
        end else if (ctrl_we) begin
            ctrl <= wr_data;
        end
    end

    // Converter owns the line only while enabled
    assign tone_active = ctrl[`BPP_TONE_EN_BIT];

endmodule
`default_nettype wire

// [tb/bidirectional_parallel_ports_bench.sv]
// Self-checking bench for the parallel port block
`timescale 1ns/100ps
`default_nettype none
module bidirectional_parallel_ports_bench
    import bpp_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, err;
    logic [6:0] a_in, a_out, a_oe;
    logic [7:0] b_in, b_out, b_oe, c_in, c_out, c_oe;
    logic [5:0] tone;
    logic [6:0] ext_a = 7'h55;
    logic [7:0] ext_b = 8'h3c;
    logic [7:0] ext_c = 8'hc3;
    logic [4:0] lat_adr [3] = '{5'h00, 5'h04, 5'h08};
    logic [4:0] dir_adr [3] = '{5'h14, 5'h18, 5'h1c};
    logic [7:0] wmask [3] = '{8'h7f, 8'hff, 8'hff};
    logic [7:0] q;
    logic [7:0] qr;
    logic e;
    logic [31:0] rdat_r;
    logic [6:0] a_oe_r;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    always #50 clock = ~clock;

    bpp_ports dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .port_a_in(a_in), .port_a_out(a_out),
        .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
        .port_c_in(c_in), .port_c_out(c_out), .port_c_oe(c_oe), .tone_level(tone));
    bpp_pins_model pins (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .c_out(c_out), .c_oe(c_oe), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c),
        .a_pin(a_in), .b_pin(b_in), .c_pin(c_in));
    // Reduced variant on the same bus, judged on read data and port A enables
    bpp_ports #(.REDUCED_PORT_A(1'b1)) dut_r (.clock(clock), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat_r), .wb_ack_o(), .wb_err_o(), .port_a_in(ext_a), .port_a_out(),
        .port_a_oe(a_oe_r), .port_b_in(ext_b), .port_b_out(), .port_b_oe(), .port_c_in(ext_c),
        .port_c_out(), .port_c_oe(), .tone_level());

    // One Wishbone cycle, held until ack or err is sampled
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clock);
        while (ack !== 1'b1 && err !== 1'b1) begin
            @(posedge clock);
        end
        q = rdat[7:0];
        qr = rdat_r[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Directions read back clear, nothing driven
    task automatic t_reset_dirs();
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, dir_adr[i], 8'h00);
            check8(q, 8'h00);
        end
        check8({1'b0, a_oe} | b_oe | c_oe, 8'h00);
    endtask

    // Write to an input port, then read the pins
    task automatic t_input_port();
        bus(1'b1, 5'h04, 8'ha5);
        check8(b_oe, 8'h00);
        check8(b_out, 8'ha5);
        bus(1'b0, 5'h04, 8'h00);
        check8(q, ext_b);
    endtask

    // Upper half output, lower half input on one port
    task automatic t_mixed_dir();
        bus(1'b1, 5'h18, 8'hf0);
        check8(b_oe, 8'hf0);
        check8(b_out, 8'ha5);
        bus(1'b0, 5'h04, 8'h00);
        check8(q, (8'ha5 & 8'hf0) | (ext_b & 8'h0f));
    endtask

    // Every port as output: latch and direction read back at width
    task automatic t_all_ports();
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, lat_adr[i], 8'h5a ^ 8'(i));
            bus(1'b1, dir_adr[i], 8'hff);
            bus(1'b0, lat_adr[i], 8'h00);
            check8(q, (8'h5a ^ 8'(i)) & wmask[i]);
            bus(1'b0, dir_adr[i], 8'h00);
            check8(q, wmask[i]);
        end
        bus(1'b0, 5'h0c, 8'h00);
        check8({7'h00, e}, 8'h01);
        check8({1'b0, a_out}, 8'h5a);
        check8(c_out, 8'h58);
        check8(c_in, 8'h58);
    endtask

    // Reduced variant: port A line 0 absent, six lines left
    task automatic t_reduced_a();
        bus(1'b1, 5'h00, 8'h7f);
        bus(1'b1, 5'h14, 8'hff);
        bus(1'b0, 5'h14, 8'h00);
        check8(qr, 8'h7e);
        check8(q, 8'h7f);
        bus(1'b0, 5'h00, 8'h00);
        check8(qr, 8'h7e);
        check8({1'b0, a_oe_r}, 8'h7e);
    endtask

    // Tone takes line 1, reset frees it and keeps the latches
    task automatic t_reset_keep();
        bus(1'b1, 5'h10, 8'hab);
        check8({2'b00, tone}, 8'h2b);
        check8({7'h00, a_oe[1]}, 8'h00);
        check8({7'h00, a_out[1]}, 8'h00);
        @(posedge clock);
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check8({2'b00, tone}, 8'h00);
        check8(b_oe | c_oe, 8'h00);
        check8(b_out, 8'h5b);
        bus(1'b1, 5'h14, 8'h02);
        check8({7'h00, a_oe[1]}, 8'h01);
        check8({7'h00, a_out[1]}, 8'h01);
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_reset_dirs();
        t_input_port();
        t_mixed_dir();
        t_all_ports();
        t_reduced_a();
        t_reset_keep();
        final_report();
    end
endmodule
`default_nettype wire

// [tb/bpp_pins_model.sv]
// Outside circuitry on the three ports
`timescale 1ns/100ps
`default_nettype none
module bpp_pins_model (
    input wire logic [6:0] a_out,
    input wire logic [6:0] a_oe,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe,
    input wire logic [6:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] ext_c,
    output logic [6:0] a_pin,
    output logic [7:0] b_pin,
    output logic [7:0] c_pin
);
    // Driven bits follow the port, the rest follow the outside levels
    assign a_pin = (a_oe & a_out) | (~a_oe & ext_a);
    assign b_pin = (b_oe & b_out) | (~b_oe & ext_b);
    assign c_pin = (c_oe & c_out) | (~c_oe & ext_c);
endmodule
`default_nettype wire

// [tb/bpp_ports_checker.sv]
// Concurrent checks on the parallel port block's ports
`timescale 1ns/100ps
`default_nettype none
module bpp_ports_checker
    import bpp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [6:0] port_a_oe,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe,
    input wire logic [7:0] port_c_oe,
    input wire logic [5:0] tone_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Request accepted at this edge
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire wr_b = take & wb_we_i & wb_sel_i[0];
    // Set once port B latch holds a known value; avoids judging unknowns
    logic written = 1'b0;
    always_ff @(posedge clock) begin
        if (wr_b && wb_adr_i == 5'h04) begin
            written <= 1'b1;
        end
    end
    dir_write_a: assert property (wr_b && wb_adr_i == 5'h18 |=>
        port_b_oe == $past(wb_dat_i[7:0]))
        else $error("direction write not seen on enables");
    latch_write_a: assert property (wr_b && wb_adr_i == 5'h04 |=>
        port_b_out == $past(wb_dat_i[7:0]))
        else $error("latch write not seen on outputs");
    latch_only_a: assert property (wr_b && wb_adr_i == 5'h04 |=> $stable(port_b_oe))
        else $error("latch write moved the enables");
    read_mix_a: assert property (take && !wb_we_i && wb_adr_i == 5'h04 |=>
        wb_dat_o[7:0] == (($past(port_b_oe) & $past(port_b_out)) |
        (~$past(port_b_oe) & $past(port_b_in))))
        else $error("read value mixes pins and latch wrongly");
    reset_dirs_a: assert property (disable iff (1'b0) reset |=>
        port_a_oe == 7'h00 && port_b_oe == 8'h00 && port_c_oe == 8'h00)
        else $error("enables not cleared by reset");
    latch_keep_a: assert property (disable iff (1'b0) reset && written |=>
        $stable(port_b_out))
        else $error("latch changed by reset");
    tone_reset_a: assert property (disable iff (1'b0) reset |=> tone_level == 6'h00)
        else $error("tone control not cleared by reset");
    unmapped_err_a: assert property (take && wb_adr_i == 5'h0c |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    ack_pulse_a: assert property (take && wb_adr_i[1:0] == 2'h0 && wb_adr_i[4:2] != 3'h3
        |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
        else $error("mapped access not acknowledged once");
endmodule
bind bpp_ports bpp_ports_checker chk (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port_a_oe,
    .port_b_in, .port_b_out, .port_b_oe, .port_c_oe, .tone_level);
`default_nettype wire
